// ### rmor_top.sv
// Margin offset register pair behind a PMBus slave, with loop reference composition.
// Assumes open-drain SCL and SDA sampled on a free-running link clock, and
// other controls from logic on the core clock.
`timescale 1ns/1ps
module rmor_top #(
  parameter logic [6:0] PMBUS_ADDR = rmor_pkg::DEV_ADDR_DEFAULT,
  parameter int SLEW_CYC = rmor_pkg::SLEW_INTERVAL_CYC
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic link_clk,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  output logic smbalert_out,
  output logic smbalert_oe,
  input wire logic loop_follower,
  input wire logic [7:0] operation,
  input wire logic [15:0] option_settings,
  input wire logic restore_req,
  input wire logic clear_faults,
  input wire logic [15:0] vout_command,
  input wire logic [15:0] vout_scale_loop,
  input wire logic [15:0] vref_trim,
  input wire logic [15:0] vout_max,
  input wire logic [15:0] vout_min,
  input wire rmor_pkg::rmor_power_t power_state,
  input wire logic [7:0] ton_rise_step,
  input wire logic [7:0] transition_step,
  input wire logic [7:0] toff_fall_step,
  output logic [15:0] loop_reference,
  output logic [31:0] loop_reference_voltage_uv,
  output logic status_byte_cml,
  output logic cml_invalid_data,
  output logic invalid_command_fault
);

  // Link domain.

  logic lrst_meta_reg, lrst_n_reg;
  logic scl_meta_reg, scl_s_reg, scl_d_reg;
  logic sda_meta_reg, sda_s_reg, sda_d_reg;
  logic fol_meta_reg, fol_s_reg;
  logic preq_meta_reg, preq_s_reg, pub_ack_reg;
  logic [15:0] up_mirror_reg, dn_mirror_reg;
  logic pub_req_reg;
  logic [15:0] snap_up_reg, snap_dn_reg;
  rmor_pkg::rmor_link_t lstate_reg, lstate_next;
  logic [3:0] bitcnt_reg, bitcnt_next;
  logic [7:0] shift_reg, shift_next;
  logic [7:0] cmd_reg, cmd_next;
  logic [7:0] lo_reg, lo_next;
  logic drive_low_reg, drive_next;
  logic rw_reg, rw_next;
  logic cmd_ok_reg, cmd_ok_next;
  logic ack_reg, ack_next;
  logic master_ack_reg, master_ack_next;
  logic ev_tog_reg, ev_tog_next;
  logic ev_kind_reg, ev_kind_next;
  logic [7:0] ev_cmd_reg, ev_cmd_next;
  logic [15:0] ev_data_reg, ev_data_next;

  // Link reset follows the core reset through two link flops.
  always_ff @(posedge link_clk) begin
    lrst_meta_reg <= resetn;
    lrst_n_reg <= lrst_meta_reg;
  end

  // Pin synchronisers; only stage two and its copy feed logic.
  always_ff @(posedge link_clk) begin
    scl_meta_reg <= scl_in;
    scl_s_reg <= scl_meta_reg;
    scl_d_reg <= scl_s_reg;
    sda_meta_reg <= sda_in;
    sda_s_reg <= sda_meta_reg;
    sda_d_reg <= sda_s_reg;
    fol_meta_reg <= loop_follower;
    fol_s_reg <= fol_meta_reg;
    preq_meta_reg <= pub_req_reg;
    preq_s_reg <= preq_meta_reg;
  end

  wire scl_rise = scl_s_reg & ~scl_d_reg;
  wire scl_fall = ~scl_s_reg & scl_d_reg;
  wire start_det = scl_s_reg & scl_d_reg & sda_d_reg & ~sda_s_reg;
  wire stop_det = scl_s_reg & scl_d_reg & ~sda_d_reg & sda_s_reg;
  wire lk_tx = (lstate_reg == rmor_pkg::LK_RLO) || (lstate_reg == rmor_pkg::LK_RHI);
  wire lk_active = (lstate_reg != rmor_pkg::LK_IDLE) && (lstate_reg != rmor_pkg::LK_DONE);
  wire cmd_ours = (shift_reg == rmor_pkg::CMD_MARGIN_UP) || (shift_reg == rmor_pkg::CMD_MARGIN_DOWN);
  wire addr_hit = (shift_reg[7:1] == PMBUS_ADDR) && (!shift_reg[0] || cmd_ok_reg);
  wire [15:0] rd_word = (cmd_reg == rmor_pkg::CMD_MARGIN_DOWN) ? dn_mirror_reg : up_mirror_reg;

  // Acknowledge for the byte just received.
  wire byte_ack = (lstate_reg == rmor_pkg::LK_ADDR) ? addr_hit :
                  (lstate_reg == rmor_pkg::LK_CMD) ? (cmd_ours && !fol_s_reg) : 1'b1;

  // Byte engine: shift in on SCL rise, drive SDA after SCL falls.
  always_comb begin
    lstate_next = lstate_reg;
    bitcnt_next = bitcnt_reg;
    shift_next = shift_reg;
    cmd_next = cmd_reg;
    lo_next = lo_reg;
    drive_next = drive_low_reg;
    rw_next = rw_reg;
    cmd_ok_next = cmd_ok_reg;
    ack_next = ack_reg;
    master_ack_next = master_ack_reg;
    ev_tog_next = ev_tog_reg;
    ev_kind_next = ev_kind_reg;
    ev_cmd_next = ev_cmd_reg;
    ev_data_next = ev_data_reg;
    if (stop_det) begin
      lstate_next = rmor_pkg::LK_IDLE;
      drive_next = 1'b0;
      cmd_ok_next = 1'b0;
    end else if (start_det) begin
      lstate_next = rmor_pkg::LK_ADDR;
      bitcnt_next = '1; // The SCL fall that ends the START wraps this to zero.
      drive_next = 1'b0;
    end else if (lk_active && scl_rise) begin
      if (bitcnt_reg == rmor_pkg::BIT_ACK) begin
        master_ack_next = ~sda_s_reg;
      end else if (!lk_tx) begin
        shift_next = {shift_reg[6:0], sda_s_reg};
      end
    end else if (lk_active && scl_fall && bitcnt_reg == rmor_pkg::BIT_LAST) begin
      bitcnt_next = rmor_pkg::BIT_ACK;
      ack_next = byte_ack;
      drive_next = lk_tx ? 1'b0 : byte_ack;
      unique case (lstate_reg)
        rmor_pkg::LK_ADDR: rw_next = shift_reg[0];
        rmor_pkg::LK_CMD: begin
          cmd_next = shift_reg;
          if (cmd_ours && fol_s_reg) begin
            ev_tog_next = ~ev_tog_reg;
            ev_kind_next = rmor_pkg::EV_BADCMD;
            ev_cmd_next = shift_reg;
          end
        end
        rmor_pkg::LK_WLO: lo_next = shift_reg;
        rmor_pkg::LK_WHI: begin
          ev_tog_next = ~ev_tog_reg;
          ev_kind_next = rmor_pkg::EV_WRITE;
          ev_cmd_next = cmd_reg;
          ev_data_next = {shift_reg, lo_reg};
        end
        rmor_pkg::LK_RLO, rmor_pkg::LK_RHI, rmor_pkg::LK_IDLE, rmor_pkg::LK_DONE: begin
        end
      endcase
    end else if (lk_active && scl_fall && bitcnt_reg == rmor_pkg::BIT_ACK) begin
      bitcnt_next = 4'h0;
      drive_next = 1'b0;
      lstate_next = rmor_pkg::LK_DONE;
      unique case (lstate_reg)
        rmor_pkg::LK_ADDR: begin
          if (ack_reg && rw_reg) begin
            lstate_next = rmor_pkg::LK_RLO;
            shift_next = rd_word[7:0];
            drive_next = ~rd_word[7];
          end else if (ack_reg) begin
            lstate_next = rmor_pkg::LK_CMD;
          end
        end
        rmor_pkg::LK_CMD: begin
          if (ack_reg) begin
            lstate_next = rmor_pkg::LK_WLO;
            cmd_ok_next = 1'b1;
          end
        end
        rmor_pkg::LK_WLO: lstate_next = rmor_pkg::LK_WHI;
        rmor_pkg::LK_RLO: begin
          if (master_ack_reg) begin
            lstate_next = rmor_pkg::LK_RHI;
            shift_next = rd_word[15:8];
            drive_next = ~rd_word[15];
          end
        end
        rmor_pkg::LK_WHI, rmor_pkg::LK_RHI, rmor_pkg::LK_IDLE, rmor_pkg::LK_DONE: begin
        end
      endcase
    end else if (lk_active && scl_fall) begin
      bitcnt_next = bitcnt_reg + 4'h1;
      if (lk_tx) begin
        shift_next = {shift_reg[6:0], 1'b0};
        drive_next = ~shift_reg[6];
      end
    end
  end

  // Link state registers.
  always_ff @(posedge link_clk) begin
    if (!lrst_n_reg) begin
      lstate_reg <= rmor_pkg::LK_IDLE;
      bitcnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      cmd_reg <= 8'h00;
      lo_reg <= 8'h00;
      drive_low_reg <= 1'b0;
      rw_reg <= 1'b0;
      cmd_ok_reg <= 1'b0;
      ack_reg <= 1'b0;
      master_ack_reg <= 1'b0;
      ev_tog_reg <= 1'b0;
      ev_kind_reg <= rmor_pkg::EV_WRITE;
      ev_cmd_reg <= 8'h00;
      ev_data_reg <= 16'h0000;
    end else begin
      lstate_reg <= lstate_next;
      bitcnt_reg <= bitcnt_next;
      shift_reg <= shift_next;
      cmd_reg <= cmd_next;
      lo_reg <= lo_next;
      drive_low_reg <= drive_next;
      rw_reg <= rw_next;
      cmd_ok_reg <= cmd_ok_next;
      ack_reg <= ack_next;
      master_ack_reg <= master_ack_next;
      ev_tog_reg <= ev_tog_next;
      ev_kind_reg <= ev_kind_next;
      ev_cmd_reg <= ev_cmd_next;
      ev_data_reg <= ev_data_next;
    end
  end

  // Mirrors take the snapshot once its request toggle has settled.
  always_ff @(posedge link_clk) begin
    if (!lrst_n_reg) begin
      pub_ack_reg <= 1'b0;
      up_mirror_reg <= rmor_pkg::UP_RESTORE_0;
      dn_mirror_reg <= rmor_pkg::DN_RESTORE_0;
    end else if (preq_s_reg != pub_ack_reg) begin
      pub_ack_reg <= preq_s_reg;
      up_mirror_reg <= snap_up_reg;
      dn_mirror_reg <= snap_dn_reg;
    end
  end

  // Open-drain SDA: the enable pulls the pin low.
  assign sda_out = 1'b0;
  assign sda_oe = drive_low_reg;

  // Core domain.

  logic ev_meta_reg, ev_s_reg, ev_d_reg;
  logic pack_meta_reg, pack_s_reg;
  logic [rmor_pkg::UP_FIELD_W-1:0] up_field_reg, up_field_next;
  logic [rmor_pkg::DN_FIELD_W-1:0] dn_field_reg, dn_field_next;
  logic restore_pend_reg;
  logic cml_reg, inv_data_reg, ivc_reg;
  logic [31:0] ref_uv_reg;

  // Event toggle and publish acknowledge cross through two flops.
  always_ff @(posedge clk) begin
    ev_meta_reg <= ev_tog_reg;
    ev_s_reg <= ev_meta_reg;
    ev_d_reg <= ev_s_reg;
    pack_meta_reg <= pub_ack_reg;
    pack_s_reg <= pack_meta_reg;
  end

  // Saturate a signed value into a range.
  function automatic logic [15:0] rmor_clamp(input logic signed [15:0] v, input logic signed [15:0] lo,
                                             input logic signed [15:0] hi);
    rmor_clamp = (v < lo) ? lo : (v > hi) ? hi : v;
  endfunction : rmor_clamp

  // The payload is stable long after the toggle, so it is read directly.
  wire ev_pulse = ev_s_reg ^ ev_d_reg;
  wire wr_ev = ev_pulse && (ev_kind_reg == rmor_pkg::EV_WRITE);
  wire up_wr = wr_ev && (ev_cmd_reg == rmor_pkg::CMD_MARGIN_UP);
  wire dn_wr = wr_ev && (ev_cmd_reg == rmor_pkg::CMD_MARGIN_DOWN);
  wire signed [15:0] wr_val = $signed(ev_data_reg);
  wire up_bad = (wr_val < rmor_pkg::UP_MIN) || (wr_val > rmor_pkg::UP_MAX);
  wire dn_bad = (wr_val < rmor_pkg::DN_MIN) || (wr_val > rmor_pkg::DN_MAX);
  wire [15:0] up_sat = rmor_clamp(wr_val, rmor_pkg::UP_MIN, rmor_pkg::UP_MAX);
  wire [15:0] dn_sat = rmor_clamp(wr_val, rmor_pkg::DN_MIN, rmor_pkg::DN_MAX);
  wire do_restore = restore_pend_reg || restore_req;
  wire [15:0] up_restore = option_settings[rmor_pkg::OPT_UP_SEL_BIT] ? rmor_pkg::UP_RESTORE_1
                                                                     : rmor_pkg::UP_RESTORE_0;
  wire [15:0] dn_restore = option_settings[rmor_pkg::OPT_DN_SEL_BIT] ? rmor_pkg::DN_RESTORE_1
                                                                     : rmor_pkg::DN_RESTORE_0;

  // Only writable bits are stored; a restore beats a same-cycle write.
  assign up_field_next = do_restore ? up_restore[rmor_pkg::UP_FIELD_W-1:0] :
                         up_wr ? up_sat[rmor_pkg::UP_FIELD_W-1:0] : up_field_reg;
  assign dn_field_next = do_restore ? dn_restore[rmor_pkg::DN_FIELD_W-1:0] :
                         dn_wr ? dn_sat[rmor_pkg::DN_FIELD_W-1:0] : dn_field_reg;

  // Read-back: zero fill over margin-up, ones fill over margin-down.
  wire [15:0] up_word = {rmor_pkg::UP_FILL, up_field_reg};
  wire [15:0] dn_word = {rmor_pkg::DN_FILL, dn_field_reg};

  // Sticky flags; an event beats a same-cycle clear.
  wire inv_set = (up_wr && up_bad) || (dn_wr && dn_bad);
  wire ivc_set = ev_pulse && (ev_kind_reg == rmor_pkg::EV_BADCMD);
  wire cml_next = inv_set || ivc_set || (cml_reg && !clear_faults);
  wire inv_next = inv_set || (inv_data_reg && !clear_faults);
  wire ivc_next = ivc_set || (ivc_reg && !clear_faults);

  // Offsets and flags; a restore is pending out of reset.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      up_field_reg <= rmor_pkg::UP_RESTORE_0[rmor_pkg::UP_FIELD_W-1:0];
      dn_field_reg <= rmor_pkg::DN_RESTORE_0[rmor_pkg::DN_FIELD_W-1:0];
      restore_pend_reg <= 1'b1;
      cml_reg <= 1'b0;
      inv_data_reg <= 1'b0;
      ivc_reg <= 1'b0;
    end else begin
      up_field_reg <= up_field_next;
      dn_field_reg <= dn_field_next;
      restore_pend_reg <= 1'b0;
      cml_reg <= cml_next;
      inv_data_reg <= inv_next;
      ivc_reg <= ivc_next;
    end
  end

  // Publish a snapshot only once the last was taken, so words never tear.
  wire pub_idle = (pub_req_reg == pack_s_reg);
  wire pub_go = pub_idle && ((snap_up_reg != up_word) || (snap_dn_reg != dn_word));
  always_ff @(posedge clk) begin
    if (!resetn) begin
      pub_req_reg <= 1'b0;
      snap_up_reg <= rmor_pkg::UP_RESTORE_0;
      snap_dn_reg <= rmor_pkg::DN_RESTORE_0;
    end else if (pub_go) begin
      pub_req_reg <= ~pub_req_reg;
      snap_up_reg <= up_word;
      snap_dn_reg <= dn_word;
    end
  end

  // Reference in steps, scale applied as a fixed-point factor.
  wire [31:0] scaled_prod = 32'(vout_command) * 32'(vout_scale_loop);
  wire signed [17:0] scaled_ref = $signed({1'b0, scaled_prod[rmor_pkg::SCALE_FRAC_W +: 17]});
  wire signed [17:0] trim_ext = 18'($signed(vref_trim));
  wire signed [17:0] up_term = operation[rmor_pkg::OP_MARGIN_HIGH_BIT] ? $signed({2'b00, up_word})
                                                                      : 18'sd0;
  wire signed [17:0] dn_term = operation[rmor_pkg::OP_MARGIN_LOW_BIT] ? 18'($signed(dn_word))
                                                                     : 18'sd0;
  wire signed [17:0] ref_sum = scaled_ref + trim_ext + up_term + dn_term;
  wire signed [17:0] ref_hi = $signed({2'b00, vout_max});
  wire signed [17:0] ref_lo = $signed({2'b00, vout_min});
  wire signed [17:0] ref_bound = (ref_sum > ref_hi) ? ref_hi : (ref_sum < ref_lo) ? ref_lo : ref_sum;

  rmor_ref_if ref_if ();

  assign ref_if.target = ref_bound[15:0];
  assign ref_if.power_state = power_state;
  assign ref_if.rise_step = ton_rise_step;
  assign ref_if.trans_step = transition_step;
  assign ref_if.fall_step = toff_fall_step;

  rmor_slew #(
    .STEP_CYC(SLEW_CYC)
  ) u_slew (
    .clk(clk),
    .resetn(resetn),
    .ref_if(ref_if.slew)
  );

  // Millivolt output (steps times 1953 over 1000), registered so it is glitch-free.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      ref_uv_reg <= 32'h0000_0000;
    end else begin
      ref_uv_reg <= (32'(ref_if.reference) * rmor_pkg::STEP_UV_NUM) / rmor_pkg::STEP_UV_DEN;
    end
  end

  // Outputs; the alert pin pulls low while any flag is held.
  assign loop_reference = ref_if.reference;
  assign loop_reference_voltage_uv = ref_uv_reg;
  assign status_byte_cml = cml_reg;
  assign cml_invalid_data = inv_data_reg;
  assign invalid_command_fault = ivc_reg;
  assign smbalert_out = 1'b0;
  assign smbalert_oe = cml_reg || inv_data_reg || ivc_reg;

endmodule : rmor_top

// ### rmor_pkg.sv
// Constants and types of the margin offset registers and the reference slew.
// Assumes a 100 MHz core clock and a free-running link clock on the PMBus pins.
// Functional notes
// - Operation bit five adds the margin-up offset to the loop reference.
// - Operation bit four adds the negative margin-down offset to the loop reference.
// - Loop follower: ignore writes, refuse access, flag invalid command, raise alert.
// - Offsets are linear counts, exponent minus nine, one count about two millivolts.
// - Margin-up offset is valid from zero through thirty-one counts.
// - Margin-down offset is valid from minus sixty-four through minus one count.
// - Out-of-range write saturates, raises alert, sets communication and invalid-data flags.
// - Resulting reference is further bounded by maximum, minimum, command, scale and trim; the code clamps it to maximum and minimum only.
// - Reference slews at start, transition or stop rate by power state.
// - Margin-up keeps low bits four to zero writable; high byte reads zero.
// - Margin-down keeps low bits five to zero writable; upper bits read ones.
// - Margin-up restores to 0009h or 000fh by its option bit.
// - Margin-down restores to fff7h or fff1h by its option bit.
// - Reference equals scaled command plus trim plus gated margin offsets.
package rmor_pkg;

  // Command codes of the two offset registers.
  localparam logic [7:0] CMD_MARGIN_UP = 8'hd5;
  localparam logic [7:0] CMD_MARGIN_DOWN = 8'hd6;
  localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h40;

  // Valid ranges in reference steps.
  localparam logic signed [15:0] UP_MIN = 16'sh0000;
  localparam logic signed [15:0] UP_MAX = 16'sh001f;
  localparam logic signed [15:0] DN_MIN = 16'shffc0;
  localparam logic signed [15:0] DN_MAX = 16'shffff;

  // Restore values selected by the option bits.
  localparam logic [15:0] UP_RESTORE_0 = 16'h0009;
  localparam logic [15:0] UP_RESTORE_1 = 16'h000f;
  localparam logic [15:0] DN_RESTORE_0 = 16'hfff7;
  localparam logic [15:0] DN_RESTORE_1 = 16'hfff1;

  // Writable field widths and the fill above them.
  localparam int UP_FIELD_W = 5;
  localparam int DN_FIELD_W = 6;
  localparam logic [10:0] UP_FILL = 11'h000;
  localparam logic [9:0] DN_FILL = 10'h3ff;

  // Bit positions in the option word and the operation byte.
  localparam int OPT_UP_SEL_BIT = 14;
  localparam int OPT_DN_SEL_BIT = 13;
  localparam int OP_MARGIN_HIGH_BIT = 5;
  localparam int OP_MARGIN_LOW_BIT = 4;

  // One reference step is 1.953 mV, kept as microvolts over a divisor.
  localparam logic [31:0] STEP_UV_NUM = 32'h0000_07a1;
  localparam logic [31:0] STEP_UV_DEN = 32'h0000_03e8;
  localparam int SCALE_FRAC_W = 8;

  // Slew pacing: one step every interval.
  localparam int CLK_PERIOD_NS = 10;
  localparam int SLEW_INTERVAL_NS = 1000;
  localparam int SLEW_INTERVAL_CYC = (SLEW_INTERVAL_NS / CLK_PERIOD_NS < 1) ? 1 : SLEW_INTERVAL_NS / CLK_PERIOD_NS;

  // Bit counter marks within a byte on the link.
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] BIT_ACK = 4'h8;

  typedef enum logic [3:0] {
    PWR_SOFT_START = 4'h1,
    PWR_STEADY = 4'h2,
    PWR_TOFF_DELAY = 4'h4,
    PWR_SOFT_STOP = 4'h8
  } rmor_power_t;

  typedef enum logic [7:0] {
    LK_IDLE = 8'h01,
    LK_ADDR = 8'h02,
    LK_CMD = 8'h04,
    LK_WLO = 8'h08,
    LK_WHI = 8'h10,
    LK_RLO = 8'h20,
    LK_RHI = 8'h40,
    LK_DONE = 8'h80
  } rmor_link_t;

  localparam logic EV_WRITE = 1'b0;
  localparam logic EV_BADCMD = 1'b1;

endpackage : rmor_pkg

// ### rmor_ref_if.sv
// Carrier between the register core and the reference slew unit.
// Assumes both ends run on the core clock.
`timescale 1ns/1ps
interface rmor_ref_if;
  logic [15:0] target;
  rmor_pkg::rmor_power_t power_state;
  logic [7:0] rise_step;
  logic [7:0] trans_step;
  logic [7:0] fall_step;
  logic [15:0] reference;

  modport core (output target, output power_state, output rise_step, output trans_step, output fall_step,
                input reference);
  modport slew (input target, input power_state, input rise_step, input trans_step, input fall_step,
                output reference);
endinterface : rmor_ref_if

// ### rmor_slew.sv
// Moves the loop reference toward its target, one bounded step per tick.
// Assumes target and step sizes come from the same clock.
`timescale 1ns/1ps
module rmor_slew #(
  parameter int STEP_CYC = rmor_pkg::SLEW_INTERVAL_CYC
) (
  input wire logic clk,
  input wire logic resetn,
  rmor_ref_if.slew ref_if
);
  localparam int CW = $clog2(STEP_CYC + 1);
  localparam logic [CW-1:0] TICK_LAST = CW'(STEP_CYC - 1);

  logic [CW-1:0] tick_cnt_reg;
  logic [CW-1:0] tick_cnt_next;
  logic [15:0] ref_reg;
  logic [15:0] ref_next;
  logic [7:0] step_sel;
  logic [15:0] gap;
  logic [15:0] step_w;
  logic tick;

  // Free-running pacing keeps the slope independent of when a change arrives.
  assign tick = (tick_cnt_reg == TICK_LAST);
  assign tick_cnt_next = tick ? '0 : tick_cnt_reg + CW'(1);

  // Rate follows the power state; an unknown state freezes the reference.
  always_comb begin
    unique case (ref_if.power_state)
      rmor_pkg::PWR_SOFT_START: step_sel = ref_if.rise_step;
      rmor_pkg::PWR_STEADY: step_sel = ref_if.trans_step;
      rmor_pkg::PWR_TOFF_DELAY: step_sel = ref_if.trans_step;
      rmor_pkg::PWR_SOFT_STOP: step_sel = ref_if.fall_step;
      default: step_sel = 8'h00;
    endcase
  end

  // Step toward the target without overshooting it.
  assign gap = (ref_reg < ref_if.target) ? ref_if.target - ref_reg : ref_reg - ref_if.target;
  assign step_w = ({8'h00, step_sel} < gap) ? {8'h00, step_sel} : gap;
  assign ref_next = !tick ? ref_reg :
                    (ref_reg < ref_if.target) ? ref_reg + step_w : ref_reg - step_w;

  // Reference and pacing registers.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      tick_cnt_reg <= '0;
      ref_reg <= 16'h0000;
    end else begin
      tick_cnt_reg <= tick_cnt_next;
      ref_reg <= ref_next;
    end
  end

  assign ref_if.reference = ref_reg;
endmodule : rmor_slew

// ### rmor_top_asserts.sv
// Checker bound to rmor_top.
// Assumes the core clock domain; the bench judges the link pins.
`timescale 1ns/1ps
module rmor_top_asserts (
  input wire logic clk,
  input wire logic resetn,
  input wire logic clear_faults,
  input wire logic [7:0] transition_step,
  input wire logic sda_out,
  input wire logic smbalert_out,
  input wire logic smbalert_oe,
  input wire logic [15:0] loop_reference,
  input wire logic [31:0] loop_reference_voltage_uv,
  input wire logic status_byte_cml,
  input wire logic cml_invalid_data,
  input wire logic invalid_command_fault
);
  // One domain: clock and reset are given once.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence ivc_rise; $rose(invalid_command_fault); endsequence
  // Not gated by power state: every rise is checked against the transition step.
  sequence ref_rise; loop_reference > $past(loop_reference); endsequence
  a_alert_tracks_flags: assert property (smbalert_oe == (status_byte_cml || cml_invalid_data ||
    invalid_command_fault)) else $error("alert mismatch");
  a_pins_drive_low: assert property (!sda_out && !smbalert_out) else $error("pin driven high");
  a_ivc_sets_cml: assert property (ivc_rise |-> status_byte_cml) else $error("ivc without cml");
  a_cml_stays_set: assert property (status_byte_cml && !clear_faults |=> status_byte_cml)
    else $error("cml dropped");
  a_data_stays_set: assert property (cml_invalid_data && !clear_faults |=> cml_invalid_data)
    else $error("data dropped");
  a_ivc_stays_set: assert property (invalid_command_fault && !clear_faults |=> invalid_command_fault)
    else $error("ivc dropped");
  a_volt_scaled: assert property (loop_reference_voltage_uv == {16'h0000, $past(loop_reference)} *
    rmor_pkg::STEP_UV_NUM / rmor_pkg::STEP_UV_DEN) else $error("voltage not scaled");
  a_slew_step_bound: assert property (ref_rise |-> loop_reference - $past(loop_reference) <=
    {8'h00, $past(transition_step)}) else $error("reference jumped");
endmodule : rmor_top_asserts
bind rmor_top rmor_top_asserts chk (.*);

// ### rmor_host.sv
// PMBus host model for write word and read word.
// Assumes the bench resolves open-drain SDA with a pull-up.
`timescale 1ns/1ps
module rmor_host #(parameter logic [6:0] ADDR = rmor_pkg::DEV_ADDR_DEFAULT) (
  output logic scl,
  output logic sda_low,
  input wire logic sda
);
  // SCL phases stay above six link periods.
  localparam int HALF_NS = 200;
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // Data moves while SCL is low and is sampled late while high.
  task automatic bit_io(input logic b, output logic r);
    #HALF_NS sda_low = !b;
    #HALF_NS scl = 1'b1;
    #HALF_NS r = sda;
    scl = 1'b0;
  endtask : bit_io
  // MSB first; the ninth bit is the acknowledge.
  task automatic xfer(input logic [7:0] tx, input logic last, output logic [7:0] rx, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(tx[i], rx[i]);
    end
    bit_io(last, r);
    ack = !r;
  endtask : xfer
  // Start or repeated start.
  task automatic start();
    #HALF_NS sda_low = 1'b0;
    #HALF_NS scl = 1'b1;
    #HALF_NS sda_low = 1'b1;
    #HALF_NS scl = 1'b0;
  endtask : start
  // Low byte first; a read NACKs its high byte.
  task automatic word(input logic [7:0] cmd, input logic rd, inout logic [15:0] d, output logic ok);
    logic a0, a1, a2, a3;
    logic [7:0] lo, hi;
    start();
    xfer({ADDR, 1'b0}, 1'b1, lo, a0);
    xfer(cmd, 1'b1, lo, a1);
    if (rd) begin
      start();
      xfer({ADDR, 1'b1}, 1'b1, lo, a2);
      xfer(8'hff, 1'b0, lo, a3);
      xfer(8'hff, 1'b1, hi, a3);
      d = {hi, lo};
    end else begin
      xfer(d[7:0], 1'b1, lo, a2);
      xfer(d[15:8], 1'b1, lo, a3);
    end
    #HALF_NS sda_low = 1'b1;
    #HALF_NS scl = 1'b1;
    #HALF_NS sda_low = 1'b0;
    ok = a0 && a1 && a2 && (a3 || rd);
  endtask : word
endmodule : rmor_host

// ### reference_margin_offset_regs_tb.sv
// Bench: table of word writes, then restore, reference and follower cases.
// Assumes rmor_host and an SDA pull-up.
`timescale 1ns/1ps
module reference_margin_offset_regs_tb;
  typedef struct packed {logic [7:0] cmd; logic [15:0] wd; logic [15:0] rd; logic bad;} rmor_row_t;
  localparam rmor_row_t ROWS [8] = '{'{8'hd5, 16'h0000, 16'h0000, 1'b0}, '{8'hd5, 16'h001f, 16'h001f, 1'b0},
    '{8'hd5, 16'h0020, 16'h001f, 1'b1}, '{8'hd5, 16'hffff, 16'h0000, 1'b1}, '{8'hd6, 16'hffc0, 16'hffc0, 1'b0},
    '{8'hd6, 16'hffff, 16'hffff, 1'b0}, '{8'hd6, 16'h0005, 16'hffff, 1'b1}, '{8'hd6, 16'hff00, 16'hffc0, 1'b1}};
  logic clk = 1'b0, link_clk = 1'b0, resetn = 1'b0, loop_follower = 1'b0, restore_req = 1'b0;
  logic clear_faults = 1'b0, sda_oe, smbalert_oe, host_low, scl, ok, status_byte_cml, cml_invalid_data;
  logic invalid_command_fault;
  logic [15:0] vref_trim = 16'h0000;
  logic [7:0] operation = 8'h00, transition_step = 8'h04;
  logic [15:0] option_settings = 16'h0000, vout_command = 16'h0064, vout_max = 16'h03e8, d, loop_reference;
  rmor_pkg::rmor_power_t power_state = rmor_pkg::PWR_STEADY;
  int miscompares = 0, check_count = 0, cycles = 0;
  wire sda = !(sda_oe || host_low);
  // The link clock is offset from the core clock.
  always #5 clk = !clk;
  initial #7 forever #15 link_clk = !link_clk;
  rmor_top #(.SLEW_CYC(2)) dut (.*, .scl_in(scl), .sda_in(sda), .sda_out(), .smbalert_out(),
    .loop_reference_voltage_uv(), .vout_scale_loop(16'h0100), .vout_min(16'h0000),
    .ton_rise_step(8'h01), .toff_fall_step(8'h01));
  rmor_host host (.scl(scl), .sda_low(host_low), .sda(sda));
  task automatic complete_run();
    $display("miscompares %0d check_count %0d", miscompares, check_count);
    if (miscompares == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : complete_run
  // A hang ends the run well past its expected length.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 90000) begin
      miscompares++;
      complete_run();
    end
  end
  task automatic check_word(input string what, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : check_word
  // Flag order: ack, cml, invalid data, invalid command, alert.
  task automatic check_flags(input logic [4:0] exp);
    logic [4:0] got = {ok, status_byte_cml, cml_invalid_data, invalid_command_fault, smbalert_oe};
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("Error flags expected %b seen %b", exp, got);
    end
  endtask : check_flags
  task automatic pulse(ref logic s);
    @(negedge clk) s = 1'b1;
    @(negedge clk) s = 1'b0;
  endtask : pulse
  // Reset outlasts the link sync; the first START waits forty core cycles.
  task automatic do_reset();
    @(negedge clk) resetn = 1'b0;
    repeat (10) @(negedge clk);
    resetn = 1'b1;
    repeat (40) @(negedge clk);
  endtask : do_reset
  task automatic read_both(input logic [15:0] up, input logic [15:0] dn);
    host.word(8'hd5, 1'b1, d, ok);
    check_word("margin up", up, d);
    host.word(8'hd6, 1'b1, d, ok);
    check_word("margin down", dn, d);
  endtask : read_both
  task automatic check_ref(input logic [7:0] op, input logic [15:0] exp);
    @(negedge clk) operation = op;
    for (int n = 0; n < 300 && loop_reference !== exp; n++) @(negedge clk);
    check_word("reference", exp, loop_reference);
  endtask : check_ref
  // Table rows, then hand-written cases.
  initial begin
    do_reset();
    foreach (ROWS[i]) begin
      d = ROWS[i].wd;
      host.word(ROWS[i].cmd, 1'b0, d, ok);
      check_flags({1'b1, ROWS[i].bad, ROWS[i].bad, 1'b0, ROWS[i].bad});
      host.word(ROWS[i].cmd, 1'b1, d, ok);
      check_word("readback", ROWS[i].rd, d);
      pulse(clear_faults);
    end
    option_settings = 16'h6000;
    do_reset();
    read_both(16'h000f, 16'hfff1);
    check_flags(5'b10000);
    @(negedge clk) option_settings = 16'h0000;
    pulse(restore_req);
    read_both(16'h0009, 16'hfff7);
    check_ref(8'h00, 16'h0064);
    check_ref(8'h20, 16'h006d);
    check_ref(8'h10, 16'h005b);
    @(negedge clk) vref_trim = 16'h0003;
    check_ref(8'h10, 16'h005e);
    @(negedge clk) vout_max = 16'h0069;
    check_ref(8'h20, 16'h0069);
    @(negedge clk) loop_follower = 1'b1;
    d = 16'h0003;
    host.word(8'hd5, 1'b0, d, ok);
    check_flags(5'b01011);
    @(negedge clk) loop_follower = 1'b0;
    host.word(8'hd5, 1'b1, d, ok);
    check_word("ignored write", 16'h0009, d);
    complete_run();
  end
endmodule : reference_margin_offset_regs_tb
